// ### hdl/pgpio_map.svh
`ifndef PGPIO_MAP_SVH
`define PGPIO_MAP_SVH

// register indices; byte address is four times the index
`define PGPIO_IDX_OUT_EN     16'h4403
`define PGPIO_IDX_DIR        16'h4404
`define PGPIO_IDX_LEVEL      16'h4405
`define PGPIO_ADDR_OUT_EN    18'h1100c
`define PGPIO_ADDR_DIR       18'h11010
`define PGPIO_ADDR_LEVEL     18'h11014
`define PGPIO_RST_OUT_EN     16'h0000
`define PGPIO_RST_DIR        16'h0000
`define PGPIO_RST_LEVEL      16'h0000
`define PGPIO_PIN_COUNT      16
`define PGPIO_SYNC_STAGES    2

`endif

// ### hdl/pgpio_pkg.sv
package pgpio_pkg;

    typedef logic [15:0] pgpio_word_type;

    // bus request from software
    typedef struct packed
    {
        logic [17:0]    addr;
        logic [31:0]    wdata;
        logic           wr;
        logic           rd;
    } pgpio_req_type;

    // pin side of the bank
    typedef struct packed
    {
        pgpio_word_type out_val;
        pgpio_word_type out_en;
    } pgpio_drive_type;

    typedef enum logic [1:0]
    {
        PGPIO_SEL_NONE  = 2'b00,
        PGPIO_SEL_OEN   = 2'b01,
        PGPIO_SEL_DIR   = 2'b10,
        PGPIO_SEL_LEVEL = 2'b11
    } pgpio_sel_type;

endpackage

// ### hdl/pgpio_sync.sv
`timescale 1ns/100ps

// two-stage synchroniser for asynchronous pin levels
module pgpio_sync
    import pgpio_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           srst,
    input  wire pgpio_word_type async_in,
    output pgpio_word_type      sync_out
);

    pgpio_word_type meta_q;
    pgpio_word_type sync_q;

    // first stage is read only by the second stage
    always_ff @(posedge sys_clk)
    begin
        meta_q <= async_in;
    end

    always_ff @(posedge sys_clk)
    begin
        sync_q <= meta_q;
    end

    assign sync_out = sync_q;

endmodule

// ### hdl/pgpio_bank.sv
`timescale 1ns/100ps
`include "pgpio_map.svh"

module pgpio_bank
    import pgpio_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           srst,
    input  wire logic [17:0]    reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [31:0]         reg_rdata,
    input  wire pgpio_word_type pin_in,
    output pgpio_word_type      pin_out,
    output pgpio_word_type      pin_oe
);

    // =========================================================
    // address decode
    // =========================================================
    function automatic pgpio_sel_type decode_sel(input logic [17:0] addr);
        case (addr)
            `PGPIO_ADDR_OUT_EN: decode_sel = PGPIO_SEL_OEN;
            `PGPIO_ADDR_DIR:    decode_sel = PGPIO_SEL_DIR;
            `PGPIO_ADDR_LEVEL:  decode_sel = PGPIO_SEL_LEVEL;
            default:            decode_sel = PGPIO_SEL_NONE;
        endcase
    endfunction

    pgpio_req_type   req;
    pgpio_sel_type   sel;
    pgpio_word_type  pin_output_enable_hi_q;
    pgpio_word_type  pin_direction_hi_q;
    pgpio_word_type  drive_level_q;
    pgpio_word_type  pin_sync;
    pgpio_word_type  pin_level_view;
    pgpio_drive_type drive;
    logic [31:0]     reg_rdata_q;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign sel = decode_sel(req.addr);

    // =========================================================
    // pin synchroniser
    // =========================================================
    pgpio_sync u_sync
    (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // =========================================================
    // control registers
    // =========================================================
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            pin_output_enable_hi_q <= `PGPIO_RST_OUT_EN;
        else if (req.wr && sel == PGPIO_SEL_OEN)
            pin_output_enable_hi_q <= req.wdata[15:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            pin_direction_hi_q <= `PGPIO_RST_DIR;
        else if (req.wr && sel == PGPIO_SEL_DIR)
            pin_direction_hi_q <= req.wdata[15:0];
    end

    // output latch holds the written level; writes land even for input pins
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            drive_level_q <= `PGPIO_RST_LEVEL;
        else if (req.wr && sel == PGPIO_SEL_LEVEL)
            drive_level_q <= req.wdata[15:0];
    end

    // =========================================================
    // pin drive, per bit
    // =========================================================
    genvar i;
    generate
        for (i = 0; i < `PGPIO_PIN_COUNT; i++)
        begin : g_pin
            // output pins read back the driven level, inputs the sampled one
            assign pin_level_view[i] = pin_direction_hi_q[i] ? drive_level_q[i]
                                                             : pin_sync[i];
            assign drive.out_en[i]   = pin_output_enable_hi_q[i];
            // mixed setting drives the latch value, which counts as unspecified
            assign drive.out_val[i]  = drive_level_q[i];
        end
    endgenerate

    assign pin_out = drive.out_val;
    assign pin_oe  = drive.out_en;

    // =========================================================
    // read port
    // =========================================================
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata_q <= 32'h0000_0000;
        else if (req.rd)
        begin
            case (sel)
                PGPIO_SEL_OEN:   reg_rdata_q <= {16'h0000, pin_output_enable_hi_q};
                PGPIO_SEL_DIR:   reg_rdata_q <= {16'h0000, pin_direction_hi_q};
                PGPIO_SEL_LEVEL: reg_rdata_q <= {16'h0000, pin_level_view};
                default:         reg_rdata_q <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata_q <= 32'h0000_0000;
    end

    assign reg_rdata = reg_rdata_q;

    // =========================================================
    // assertions
    // =========================================================
    pgpio_word_type pin_past1;
    pgpio_word_type pin_past2;
    always_ff @(posedge sys_clk)
    begin
        pin_past1 <= pin_in;
        pin_past2 <= pin_past1;
    end

    a_oen_reset_zero: assert property (@(posedge sys_clk)
        $past(srst) |-> pin_output_enable_hi_q == 16'h0000)
        else $error("output enable not cleared by reset");

    a_oen_write_lands: assert property (@(posedge sys_clk) disable iff (srst)
        (reg_wr && reg_addr == `PGPIO_ADDR_OUT_EN) |=> pin_oe == $past(reg_wdata[15:0]))
        else $error("output enable write not reflected on pins");

    a_no_drive_off: assert property (@(posedge sys_clk) disable iff (srst)
        (pin_output_enable_hi_q == 16'h0000) |-> pin_oe == 16'h0000)
        else $error("pin driven while enable clear");

    a_drive_when_on: assert property (@(posedge sys_clk) disable iff (srst)
        pin_oe == pin_output_enable_hi_q)
        else $error("enable and pin drive disagree");

    a_dir_reset_zero: assert property (@(posedge sys_clk)
        $past(srst) |-> pin_direction_hi_q == 16'h0000)
        else $error("direction not cleared by reset");

    a_input_readback: assert property (@(posedge sys_clk) disable iff (srst)
        (reg_rd && reg_addr == `PGPIO_ADDR_LEVEL && pin_direction_hi_q == 16'h0000
         && $stable(pin_direction_hi_q))
        |=> reg_rdata[15:0] == $past(pin_past2))
        else $error("input read does not show synchronised level");

    a_output_readback: assert property (@(posedge sys_clk) disable iff (srst)
        (reg_rd && reg_addr == `PGPIO_ADDR_LEVEL && pin_direction_hi_q == 16'hffff)
        |=> reg_rdata[15:0] == $past(drive_level_q))
        else $error("output read does not show driven level");

    a_write_drives: assert property (@(posedge sys_clk) disable iff (srst)
        (reg_wr && reg_addr == `PGPIO_ADDR_LEVEL) |=> pin_out == $past(reg_wdata[15:0]))
        else $error("data write not driven on pins");

    a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (srst)
        pin_sync == pin_past2)
        else $error("synchroniser depth wrong");

    a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (srst)
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside answer cycle");

    c_enable_all: cover property (@(posedge sys_clk) pin_oe == 16'hffff);
    c_read_level: cover property (@(posedge sys_clk) reg_rd && reg_addr == `PGPIO_ADDR_LEVEL);
    c_back_to_back: cover property (@(posedge sys_clk) reg_wr ##1 reg_rd);

endmodule

// ### test/pgpio_board_model.sv
`timescale 1ns/100ps

// ==========================================
// board logic on the sixteen pins
module pgpio_board_model
    import pgpio_pkg::*;
(
    input  wire pgpio_word_type pin_out,
    input  wire pgpio_word_type pin_oe,
    input  wire pgpio_word_type ext_level,
    output pgpio_word_type      pin_in
);
    // driven pins read back the device level, released pins follow the board
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### test/tb_pgpio_bank.sv
`timescale 1ns/100ps
`include "pgpio_map.svh"

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module tb_pgpio_bank
    import pgpio_pkg::*;
;
    logic           sys_clk = 1'b0;
    logic           srst = 1'b1;
    logic [17:0]    reg_addr = 18'h00000;
    logic [31:0]    reg_wdata = 32'h00000000;
    logic           reg_wr = 1'b0;
    logic           reg_rd = 1'b0;
    logic [31:0]    reg_rdata;
    pgpio_word_type pin_in;
    pgpio_word_type pin_out;
    pgpio_word_type pin_oe;
    pgpio_word_type ext_level = 16'h5a3c;
    logic [31:0]    v;
    int             errors = 0;
    int             total_checks = 0;

    always #4 sys_clk = ~sys_clk;

    pgpio_bank i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));

    pgpio_board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

    // ==========================================
    // register bus cycles
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [17:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        rd(`PGPIO_ADDR_OUT_EN, v); `CHK(v, 32'h00000000)
        rd(`PGPIO_ADDR_DIR, v); `CHK(v, 32'h00000000)
        `CHK(pin_oe, 16'h0000)
        rd(`PGPIO_ADDR_LEVEL, v); `CHK(v, 32'h00005a3c)
        $display("test reset done");
    endtask

    task automatic t_input();
        ext_level <= 16'hc3a5;
        rd(`PGPIO_ADDR_LEVEL, v); `CHK(v, 32'h00005a3c)
        rd(`PGPIO_ADDR_LEVEL, v); `CHK(v, 32'h0000c3a5)
        $display("test input done");
    endtask

    task automatic t_output();
        wr(`PGPIO_ADDR_OUT_EN, 32'h0000ff00);
        wr(`PGPIO_ADDR_DIR, 32'h0000ff00);
        wr(`PGPIO_ADDR_LEVEL, 32'h00001234);
        `CHK(pin_oe, 16'hff00)
        `CHK(pin_out & pin_oe, 16'h1200)
        rd(`PGPIO_ADDR_LEVEL, v); `CHK(v, 32'h000012a5)
        wr(`PGPIO_ADDR_LEVEL, 32'h0000ffff);
        `CHK(pin_out & pin_oe, 16'hff00)
        wr(`PGPIO_ADDR_LEVEL, 32'h00000000);
        `CHK(pin_out & pin_oe, 16'h0000)
        $display("test output done");
    endtask

    task automatic t_access();
        wr(`PGPIO_ADDR_OUT_EN, 32'hffffa5a5);
        wr(`PGPIO_ADDR_DIR, 32'hffffa5a5);
        rd(`PGPIO_ADDR_OUT_EN, v); `CHK(v, 32'h0000a5a5)
        rd(`PGPIO_ADDR_DIR, v); `CHK(v, 32'h0000a5a5)
        `CHK(pin_oe, 16'ha5a5)
        wr(18'h11018, 32'h0000ffff);
        rd(18'h11018, v); `CHK(v, 32'h00000000)
        rd(`PGPIO_ADDR_DIR, v); `CHK(v, 32'h0000a5a5)
        $display("test access done");
    endtask

    task automatic t_rst2();
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        #1 `CHK(pin_oe, 16'h0000)
        @(posedge sys_clk);
        rd(`PGPIO_ADDR_OUT_EN, v); `CHK(v, 32'h00000000)
        rd(`PGPIO_ADDR_DIR, v); `CHK(v, 32'h00000000)
        $display("test second reset done");
    endtask

    // ==========================================
    // verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_input();
        t_output();
        t_access();
        t_rst2();
        print_verdict();
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end
endmodule
